// ===== pmd_module_clock_gate.v
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "pmd_regs.vh"
// Notes on behaviour
// - bits 7..0 stop capture/compare units eight..one
// - bit 7 stops the crc engine
// - bit 1 stops the second i2c
// - crc/i2c and nibble registers primary core only
// - bit 3 stops reference clock output
// - bits 13..8 stop dma channels five..zero
// - bit 8 stops comparator one
// - bit 3 stops the trigger generator
// - bits 12,11 stop nibble units two,one
// - bits 5..2 stop logic cells four..one
// - bit 1 stops the current source
// - lock bit 11 permits disable writes
// - unimplemented bits ignore writes, read zero
// - all bits reset to zero
// - change takes effect one cycle later
// - disabled module registers ignore writes, invalid reads
module pmd_module_clock_gate (
	// clock and reset
	input  wire        clk,
	input  wire        nrst,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// per-module disable levels, one cycle after the write
	output reg  [7:0]  capcomp_off,
	output reg         crc_engine_off,
	output reg         second_i2c_off,
	output reg         refclock_out_off,
	output reg  [5:0]  dma_off,
	output reg         comparator1_off,
	output reg         trigger_gen_off,
	output reg         nibble_tx2_off,
	output reg         nibble_tx1_off,
	output reg  [3:0]  logic_cell_off,
	output reg         current_source_off,
	// gated module clocks
	output wire [25:0] module_clk
);
	////////////////////////////////////////////////////////////////////////////

	reg  [15:0] capcomp_reg;
	reg  [15:0] crc_i2c_reg;
	reg  [15:0] refclk_reg;
	reg  [15:0] dma_reg;
	reg  [15:0] cmp_trig_reg;
	reg  [15:0] nib_logic_reg;
	reg  [15:0] lock_reg;
	reg  [31:0] next_prdata;
	reg         addr_hit;
	wire        disable_write_permit;
	wire        setup;
	wire        wr_go;
	wire [15:0] wdata;
	// one gate per disable bit: 8 + 3 + 6 + 2 + 2 + 4 + 1 = 26
	wire [25:0] off_vec;

	// merge write data into the implemented bits only
	function [15:0] merge;
		input [15:0] old_val;
		input [15:0] new_val;
		input [15:0] mask;
		input [1:0]  strb;
		reg   [15:0] lane;
		begin
			lane  = {{8{strb[1]}}, {8{strb[0]}}} & mask;
			merge = (old_val & ~lane) | (new_val & lane);
		end
	endfunction

	assign disable_write_permit = lock_reg[`PMD_BIT_PERMIT];
	assign setup = psel & ~penable;
	assign wdata = pwdata[15:0];
	// registered pready rises with penable: the access phase always completes without a wait state
	assign wr_go = psel & penable & pready & pwrite & addr_hit;

	////////////////////////////////////////////////////////////////////////////
	// address decode and read mux

	always @* begin
		addr_hit    = 1'b1;
		next_prdata = 32'h00000000;
		case (paddr)
		`PMD_OFF_CAPCOMP:   next_prdata = {16'h0000, capcomp_reg};
		`PMD_OFF_CRC_I2C:   next_prdata = {16'h0000, crc_i2c_reg};
		`PMD_OFF_REFCLK:    next_prdata = {16'h0000, refclk_reg};
		`PMD_OFF_DMA:       next_prdata = {16'h0000, dma_reg};
		`PMD_OFF_CMP_TRIG:  next_prdata = {16'h0000, cmp_trig_reg};
		`PMD_OFF_NIB_LOGIC: next_prdata = {16'h0000, nib_logic_reg};
		`PMD_OFF_LOCK:      next_prdata = {16'h0000, lock_reg};
		default:            addr_hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// apb handshake

	always @(posedge clk) begin
		if (!nrst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~addr_hit;
			if (setup & ~pwrite)
				prdata <= next_prdata;
			else if (!psel)
				prdata <= 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register file

	always @(posedge clk) begin
		if (!nrst) begin
			capcomp_reg   <= `PMD_RESET_VAL;
			crc_i2c_reg   <= `PMD_RESET_VAL;
			refclk_reg    <= `PMD_RESET_VAL;
			dma_reg       <= `PMD_RESET_VAL;
			cmp_trig_reg  <= `PMD_RESET_VAL;
			nib_logic_reg <= `PMD_RESET_VAL;
			lock_reg      <= `PMD_RESET_VAL;
		end else if (wr_go) begin
			// the lock itself stays writable, otherwise it could never open
			if (paddr == `PMD_OFF_LOCK)
				lock_reg <= merge(lock_reg, wdata, `PMD_MASK_LOCK, pstrb[1:0]);
			// blocked writes drop whole, never a partial update
			if (disable_write_permit) begin
				case (paddr)
				`PMD_OFF_CAPCOMP:
					capcomp_reg <= merge(capcomp_reg, wdata,
						`PMD_MASK_CAPCOMP, pstrb[1:0]);
				`PMD_OFF_CRC_I2C:
					crc_i2c_reg <= merge(crc_i2c_reg, wdata,
						`PMD_MASK_CRC_I2C, pstrb[1:0]);
				`PMD_OFF_REFCLK:
					refclk_reg <= merge(refclk_reg, wdata,
						`PMD_MASK_REFCLK, pstrb[1:0]);
				`PMD_OFF_DMA:
					dma_reg <= merge(dma_reg, wdata,
						`PMD_MASK_DMA, pstrb[1:0]);
				`PMD_OFF_CMP_TRIG:
					cmp_trig_reg <= merge(cmp_trig_reg, wdata,
						`PMD_MASK_CMP_TRIG, pstrb[1:0]);
				`PMD_OFF_NIB_LOGIC:
					nib_logic_reg <= merge(nib_logic_reg, wdata,
						`PMD_MASK_NIB_LOGIC, pstrb[1:0]);
				default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// disable outputs, registered once more: one cycle after the write

	always @(posedge clk) begin
		if (!nrst) begin
			capcomp_off        <= 8'h00;
			crc_engine_off     <= 1'b0;
			second_i2c_off     <= 1'b0;
			refclock_out_off   <= 1'b0;
			dma_off            <= 6'h00;
			comparator1_off    <= 1'b0;
			trigger_gen_off    <= 1'b0;
			nibble_tx2_off     <= 1'b0;
			nibble_tx1_off     <= 1'b0;
			logic_cell_off     <= 4'h0;
			current_source_off <= 1'b0;
		end else begin
			capcomp_off        <= capcomp_reg[7:0];
			crc_engine_off     <= crc_i2c_reg[`PMD_BIT_CRC];
			second_i2c_off     <= crc_i2c_reg[`PMD_BIT_I2C2];
			refclock_out_off   <= refclk_reg[`PMD_BIT_REFCLK];
			dma_off            <= dma_reg[`PMD_BIT_DMA_LO +: 6];
			comparator1_off    <= cmp_trig_reg[`PMD_BIT_CMP1];
			trigger_gen_off    <= cmp_trig_reg[`PMD_BIT_TRIG];
			nibble_tx2_off     <= nib_logic_reg[`PMD_BIT_NIB1 + 1];
			nibble_tx1_off     <= nib_logic_reg[`PMD_BIT_NIB1];
			logic_cell_off     <= nib_logic_reg[`PMD_BIT_LOGIC_LO +: 4];
			current_source_off <= nib_logic_reg[`PMD_BIT_BIAS];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// clock gates; a stopped module's registers see no edge, so its writes
	// are lost and its reads stale, which is what software must expect

	assign off_vec = {current_source_off, logic_cell_off, nibble_tx1_off,
		nibble_tx2_off, trigger_gen_off, comparator1_off, dma_off,
		refclock_out_off, second_i2c_off, crc_engine_off, capcomp_off};

	genvar g;
	generate
		for (g = 0; g < `PMD_NUM_GATES; g = g + 1) begin : gate
			pmd_clock_gate u_gate (
				.clk      (clk),
				.gate_off (off_vec[g]),
				.gclk     (module_clk[g])
			);
		end
	endgenerate
endmodule // pmd_module_clock_gate

// ===== pmd_regs.vh
`ifndef PMD_REGS_VH
`define PMD_REGS_VH
// register byte offsets on the apb bus
`define PMD_OFF_CAPCOMP   12'h000
`define PMD_OFF_CRC_I2C   12'h004
`define PMD_OFF_REFCLK    12'h008
`define PMD_OFF_DMA       12'h00C
`define PMD_OFF_CMP_TRIG  12'h010
`define PMD_OFF_NIB_LOGIC 12'h014
`define PMD_OFF_LOCK      12'h018
// implemented-bit masks per register
`define PMD_MASK_CAPCOMP   16'h00FF
`define PMD_MASK_CRC_I2C   16'h0082
`define PMD_MASK_REFCLK    16'h0008
`define PMD_MASK_DMA       16'h3F00
`define PMD_MASK_CMP_TRIG  16'h0108
`define PMD_MASK_NIB_LOGIC 16'h183E
`define PMD_MASK_LOCK      16'h0800
// field positions
`define PMD_BIT_CRC        7
`define PMD_BIT_I2C2       1
`define PMD_BIT_REFCLK     3
`define PMD_BIT_DMA_LO     8
`define PMD_BIT_CMP1       8
`define PMD_BIT_TRIG       3
`define PMD_BIT_NIB1       11
`define PMD_BIT_LOGIC_LO   2
`define PMD_BIT_BIAS       1
`define PMD_BIT_PERMIT     11
// reset value of every register
`define PMD_RESET_VAL      16'h0000
// number of gated modules
`define PMD_NUM_GATES      26
`endif

// ===== pmd_clock_gate.v
`timescale 1ns/100ps
// latch-free, glitch-free gate: enable is retimed on the falling edge so it
// only changes while clk is low
module pmd_clock_gate (
	// clock
	input  wire clk,
	// control
	input  wire gate_off,
	// gated clock
	output wire gclk
);
	reg en_low;

	always @(negedge clk) begin
		en_low <= ~gate_off;
	end

	assign gclk = clk & en_low;
endmodule // pmd_clock_gate

// ===== pmd_props.sv
`timescale 1ns/100ps
module pmd_props (
	// clock and reset
	input wire        clk,
	input wire        nrst,
	// apb slave
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	// disable levels
	input wire [7:0]  capcomp_off,
	input wire [5:0]  dma_off
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	a_ready_after_setup: assert property (s_setup |=> s_access) else $error("no answer after setup");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
	a_unmapped_err: assert property (s_access ##0 paddr > 12'h018 |-> pslverr)
		else $error("unmapped address not flagged");
	a_upper_zero: assert property (s_access ##0 !pwrite |-> prdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_capcomp_high: assert property (s_access ##0 (!pwrite && paddr == 12'h000) |-> prdata[15:8] == 8'h00)
		else $error("capture high byte not zero");
	a_dma_unimpl: assert property (s_access ##0 (!pwrite && paddr == 12'h00C)
		|-> prdata[7:0] == 8'h00 && prdata[15:14] == 2'h0)
		else $error("dma unused bits not zero");
	a_reset_clear: assert property ($rose(nrst) |-> capcomp_off == 8'h00 && dma_off == 6'h00)
		else $error("disable levels not cleared by reset");
	// a level may only move shortly after a completed write
	a_off_cause: assert property ($changed(capcomp_off) || $changed(dma_off)
		|-> $past(pready && pwrite) || $past(pready && pwrite, 2))
		else $error("disable level moved without a write");
endmodule // pmd_props

// ===== pmd_periph_model.sv
`timescale 1ns/100ps
module pmd_periph_model (
	// gated clock and reset
	input wire       gclk,
	input wire       nrst,
	// activity seen by the peripheral
	output reg [7:0] ticks
);
	// runs only on the gated clock, so a stopped gate freezes it
	always @(posedge gclk) begin
		if (!nrst)
			ticks <= 8'h00;
		else
			ticks <= ticks + 8'h01;
	end
endmodule // pmd_periph_model

// ===== tb.sv
`timescale 1ns/100ps
module tb;
	reg         clk, nrst, psel, penable, pwrite, er;
	reg  [11:0] paddr;
	reg  [31:0] pwdata, rd;
	wire [31:0] prdata;
	wire        pready, pslverr, crc, i2c, rfo, cmp, trg, nb2, nb1, bias;
	wire [7:0]  capcomp_off, ticks;
	wire [5:0]  dma_off;
	wire [3:0]  cells;
	wire [25:0] module_clk;
	reg  [7:0]  t0;
	integer     n_fail, check_count, k, i;
	// expected readback per row after writing all ones, row k at byte address 4*k
	localparam [111:0] EXP = {16'h0800, 16'h183E, 16'h0108, 16'h3F00, 16'h0008, 16'h0082, 16'h00FF};
	pmd_module_clock_gate u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .capcomp_off(capcomp_off), .crc_engine_off(crc),
		.second_i2c_off(i2c), .refclock_out_off(rfo), .dma_off(dma_off), .comparator1_off(cmp),
		.trigger_gen_off(trg), .nibble_tx2_off(nb2), .nibble_tx1_off(nb1),
		.logic_cell_off(cells), .current_source_off(bias), .module_clk(module_clk));
	pmd_periph_model u_model (.gclk(module_clk[0]), .nrst(nrst), .ticks(ticks));
	always #2.5 clk = ~clk;
	////////////////////////////////////////////////////////////////
	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", check_count, n_fail);
			if (n_fail == 0 && check_count > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				$display("BAD %0t got %h expected %h", $time, got, exp);
				n_fail = n_fail + 1;
			end
		end
	endtask
	task apb(input [11:0] a, input [15:0] d, input w, output [31:0] r, output e);
		begin
			@(posedge clk);
			psel <= 1'b1;
			penable <= 1'b0;
			paddr <= a;
			pwrite <= w;
			pwdata <= {16'h0000, d};
			@(posedge clk);
			penable <= 1'b1;
			i = 0;
			@(posedge clk);
			while (pready !== 1'b1 && i < 20) begin
				i = i + 1;
				@(posedge clk);
			end
			if (i >= 20) begin
				$display("BAD %0t no pready", $time);
				n_fail = n_fail + 1;
				disable run;
			end
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		begin : run
		clk = 1'b0; nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0; n_fail = 0; check_count = 0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		// lock starts closed, so these writes must not land
		for (k = 0; k < 6; k = k + 1) apb(k * 4, 16'hFFFF, 1'b1, rd, er);
		for (k = 0; k < 7; k = k + 1) begin
			apb(k * 4, 16'h0000, 1'b0, rd, er);
			chk(rd, 32'h0);
		end
		$display("test reset and lock done");
		apb(12'h018, 16'h0800, 1'b1, rd, er);
		for (k = 0; k < 7; k = k + 1) begin
			apb(k * 4, 16'hFFFF, 1'b1, rd, er);
			apb(k * 4, 16'h0000, 1'b0, rd, er);
			chk(rd, {16'h0000, EXP[k * 16 +: 16]});
		end
		chk({capcomp_off, crc, i2c, rfo, dma_off, cmp, trg, nb2, nb1, cells, bias}, 32'h03FFFFFF);
		$display("test table done");
		apb(12'h01C, 16'hFFFF, 1'b0, rd, er);
		chk(er, 32'h1);
		@(negedge clk) t0 = ticks;
		repeat (10) @(negedge clk);
		chk(ticks, t0);
		apb(12'h000, 16'h0000, 1'b1, rd, er);
		repeat (3) @(negedge clk);
		t0 = ticks;
		repeat (10) @(negedge clk);
		chk(ticks, t0 + 8'h0A);
		$display("test gate done");
		// second reset in mid-run: the lock and nibble/logic registers and every level must clear again
		@(posedge clk);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		apb(12'h018, 16'h0000, 1'b0, rd, er);
		chk(rd, 32'h0);
		apb(12'h014, 16'h0000, 1'b0, rd, er);
		chk(rd, 32'h0);
		chk({capcomp_off, crc, i2c, rfo, dma_off, cmp, trg, nb2, nb1, cells, bias}, 32'h0);
		$display("test mid reset done");
		end
		tally_and_finish;
	end
endmodule // tb
bind pmd_module_clock_gate pmd_props u_props (.clk(clk), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .capcomp_off(capcomp_off), .dma_off(dma_off));
